// ---- sar_adc_control.sv ----
`timescale 1ns/1ps
module sar_adc_control import sar_adc_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int TAD_CNT = TAD_CYCLES
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_pin,
  input wire logic sleep_mode,
  output logic sample_close,
  output logic [RESULT_BITS-1:0] dac_code,
  output logic [3:0] mux_channel,
  output logic vref_pos_from_pin,
  output logic vref_neg_from_pin,
  output logic [15:0] analog_pin_enable,
  output logic converter_power,
  output logic irq
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  conv_ctrl_t ctrl, next_ctrl;
  logic [7:0] pin_config, next_pin_config;
  logic [18:0] analog_config, next_analog_config;
  logic [RESULT_BITS-1:0] result, next_result;
  logic [1:0] int_status, next_int_status;
  logic [1:0] int_mask, next_int_mask;
  logic next_irq;

  // ----------------------------------------
  // Bus channel state
  // ----------------------------------------
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [5:0] aw_idx, next_aw_idx;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic next_awready, next_wready, next_arready;

  // ----------------------------------------
  // Conversion clock and engine wiring
  // ----------------------------------------
  logic [15:0] tad_cnt, next_tad_cnt;
  logic tad_pulse, next_tad_pulse;
  logic tad_en;
  logic cmp_sync;
  logic eng_start, eng_abort;
  logic eng_busy, eng_sampling, eng_done;
  logic [RESULT_BITS-1:0] eng_trial, eng_result;
  logic do_write;
  logic [31:0] merged;
  logic wr_ctrl;
  conv_ctrl_t wr_val;
  logic start_req, reserved_sel, refused;

  // Merges written bytes into the old word under the strobes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  // Returns the read view of a register, zero for an unmapped index.
  function automatic logic [31:0] read_view(input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      IDX_CONV_CTRL: v = {24'h000000, ctrl};
      IDX_PIN_CONFIG: v = {24'h000000, pin_config};
      IDX_RESULT_HIGH: v = {22'h000000, result[9:8], 8'h00} >> 8;
      IDX_RESULT_LOW: v = {24'h000000, result[7:0]};
      IDX_ANALOG_CONFIG: v = {13'h0000, analog_config};
      IDX_INT_STATUS: v = {30'h00000000, int_status};
      IDX_INT_MASK: v = {30'h00000000, int_mask};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Tells whether an index names a register.
  function automatic logic mapped(input logic [5:0] idx);
    return idx inside {IDX_CONV_CTRL, IDX_PIN_CONFIG, IDX_RESULT_HIGH,
      IDX_RESULT_LOW, IDX_ANALOG_CONFIG, IDX_INT_STATUS, IDX_INT_MASK};
  endfunction

  // The comparator output is an analog pin; resynchronise it.
  sar_sync2 #(.W(1)) u_cmp_sync (
    .clk(clk),
    .srst(srst),
    .din(cmp_pin),
    .dout(cmp_sync)
  );

  sar_engine u_engine (
    .clk(clk),
    .srst(srst),
    .start(eng_start),
    .abort(eng_abort),
    .step_en(tad_en),
    .cmp_high(cmp_sync),
    .busy(eng_busy),
    .sampling(eng_sampling),
    .done(eng_done),
    .trial(eng_trial),
    .result(eng_result)
  );

  // ----------------------------------------
  // Conversion clock divider
  // ----------------------------------------
  // Divider runs only while the converter is powered.
  always_comb
  begin
    next_tad_cnt = 16'h0000;
    next_tad_pulse = 1'b0;
    if (ctrl.converter_on)
    begin
      if (tad_cnt == 16'(TAD_CNT - 1))
        next_tad_pulse = 1'b1;
      else
        next_tad_cnt = tad_cnt + 16'h0001;
    end
  end

  assign tad_en = tad_pulse && (!sleep_mode || analog_config[AC_RC_CLOCK_BIT]);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tad_cnt <= 16'h0000;
      tad_pulse <= 1'b0;
    end
    else
    begin
      tad_cnt <= next_tad_cnt;
      tad_pulse <= next_tad_pulse;
    end
  end

  // ----------------------------------------
  // Write decode and conversion start
  // ----------------------------------------
  // A write goes ahead once both address and data are held.
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_comb
  begin
    merged = merge_bytes(read_view(aw_idx), w_data, w_strb);
  end
  assign wr_ctrl = do_write && aw_idx == IDX_CONV_CTRL && w_strb[0];
  assign wr_val = conv_ctrl_t'(merged[7:0]);
  assign reserved_sel = CHANNELS <= 12 && wr_val.channel_select[3:2] == 2'h3;
  assign start_req = wr_ctrl && wr_val.go && wr_val.converter_on && !eng_busy;
  assign refused = start_req && reserved_sel;
  assign eng_start = start_req && !reserved_sel;
  assign eng_abort = !ctrl.converter_on;

  // Register file next values; hardware events win over clears.
  always_comb
  begin
    next_ctrl = ctrl;
    next_pin_config = pin_config;
    next_analog_config = analog_config;
    next_result = result;
    next_int_mask = int_mask;
    next_int_status = int_status;
    if (wr_ctrl)
    begin
      next_ctrl.channel_select = wr_val.channel_select;
      next_ctrl.converter_on = wr_val.converter_on;
      next_ctrl.go = ctrl.go || eng_start;
    end
    if (do_write && aw_idx == IDX_PIN_CONFIG)
      next_pin_config = merged[7:0] & PIN_CONFIG_MASK;
    if (do_write && aw_idx == IDX_ANALOG_CONFIG)
      next_analog_config = merged[18:0];
    if (do_write && aw_idx == IDX_INT_MASK)
      next_int_mask = merged[1:0];
    if (do_write && aw_idx == IDX_INT_STATUS)
      next_int_status = int_status & ~merged[1:0];
    if (eng_done || !next_ctrl.converter_on)
      next_ctrl.go = 1'b0;
    if (eng_done)
      next_result = eng_result;
    next_int_status[EV_DONE_BIT] = next_int_status[EV_DONE_BIT] | eng_done;
    next_int_status[EV_REFUSED_BIT] = next_int_status[EV_REFUSED_BIT] | refused;
    next_irq = |(next_int_status & next_int_mask);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl <= conv_ctrl_t'(CONV_CTRL_RESET);
      pin_config <= PIN_CONFIG_RESET;
      analog_config <= ANALOG_CONFIG_RESET;
      result <= '0;
      int_status <= INT_RESET;
      int_mask <= INT_RESET;
      irq <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      pin_config <= next_pin_config;
      analog_config <= next_analog_config;
      result <= next_result;
      int_status <= next_int_status;
      int_mask <= next_int_mask;
      irq <= next_irq;
    end
  end

  // ----------------------------------------
  // Bus slave channels
  // ----------------------------------------
  // Address and data are caught in either order; one write and one read at a time.
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = read_view(s_axi_araddr[7:2]);
      next_rresp = mapped(s_axi_araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Analog side outputs
  // ----------------------------------------
  // Registered controls toward the analog front end.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sample_close <= 1'b0;
      dac_code <= '0;
      mux_channel <= 4'h0;
      vref_pos_from_pin <= 1'b0;
      vref_neg_from_pin <= 1'b0;
      analog_pin_enable <= 16'h0000;
      converter_power <= 1'b0;
    end
    else
    begin
      sample_close <= eng_sampling;
      dac_code <= eng_trial;
      mux_channel <= next_ctrl.channel_select;
      vref_pos_from_pin <= next_analog_config[AC_VREF_POS_BIT];
      vref_neg_from_pin <= next_analog_config[AC_VREF_NEG_BIT];
      analog_pin_enable <= next_analog_config[15:0];
      converter_power <= next_ctrl.converter_on;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_start_taken;
    eng_start ##1 ctrl.go;
  endsequence

  AST_START_SETS_GO: assert property (@(posedge clk) disable iff (srst)
    eng_start |=> ctrl.go && eng_busy)
    else $error("Start did not raise go.");

  AST_GO_CLEARS: assert property (@(posedge clk) disable iff (srst)
    eng_done |=> !ctrl.go)
    else $error("Go stayed set after completion.");

  AST_GO_HOLDS: assert property (@(posedge clk) disable iff (srst)
    s_start_taken |-> ctrl.go throughout (##[0:3] 1'b1))
    else $error("Go dropped right after start.");

  AST_OFF_ABORTS: assert property (@(posedge clk) disable iff (srst)
    !ctrl.converter_on && !next_ctrl.converter_on |=> !eng_busy && !ctrl.go && !tad_pulse)
    else $error("Conversion went on with converter off.");

  AST_SLEEP_STALL: assert property (@(posedge clk) disable iff (srst)
    sleep_mode && !analog_config[AC_RC_CLOCK_BIT] |-> !tad_en)
    else $error("Conversion stepped in sleep without RC clock.");

  AST_RESERVED: assert property (@(posedge clk) disable iff (srst)
    refused |=> !ctrl.go && !eng_busy && int_status[EV_REFUSED_BIT])
    else $error("Reserved channel started a conversion.");

  AST_RESULT: assert property (@(posedge clk) disable iff (srst)
    eng_done |=> result == $past(eng_result))
    else $error("Result not captured on completion.");

  AST_IRQ: assert property (@(posedge clk) disable iff (srst)
    eng_done && int_mask[EV_DONE_BIT] |=> irq && int_status[EV_DONE_BIT])
    else $error("Completion did not raise the interrupt.");

  AST_POWER: assert property (@(posedge clk) disable iff (srst)
    $fell(ctrl.converter_on) |-> !converter_power ##2 !sample_close)
    else $error("Power output did not follow converter_on.");
endmodule

// ---- sar_adc_pkg.sv ----
package sar_adc_pkg;

  // Timing: system clock and conversion clock period.
  localparam int CLK_PERIOD_NS = 4;
  localparam int TAD_NS = 1000;
  localparam int TAD_CYCLES = (TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_TAD = 12;
  localparam int RESULT_BITS = 10;

  // Register indices; byte address is four times the index.
  localparam logic [5:0] IDX_CONV_CTRL = 6'h14;
  localparam logic [5:0] IDX_PIN_CONFIG = 6'h15;
  localparam logic [5:0] IDX_RESULT_HIGH = 6'h16;
  localparam logic [5:0] IDX_RESULT_LOW = 6'h17;
  localparam logic [5:0] IDX_ANALOG_CONFIG = 6'h18;
  localparam logic [5:0] IDX_INT_STATUS = 6'h19;
  localparam logic [5:0] IDX_INT_MASK = 6'h1A;

  // Reset values and writable masks.
  localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
  localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
  localparam logic [7:0] PIN_CONFIG_MASK = 8'hEF;
  localparam logic [18:0] ANALOG_CONFIG_RESET = 19'h00000;
  localparam logic [1:0] INT_RESET = 2'h0;

  // Field positions in analog_config and interrupt registers.
  localparam int AC_VREF_POS_BIT = 16;
  localparam int AC_VREF_NEG_BIT = 17;
  localparam int AC_RC_CLOCK_BIT = 18;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_REFUSED_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [9:0] TRIAL_MSB = 10'h200;

  // Layout of conversion_control.
  typedef struct packed {
    logic [3:0] channel_select;
    logic unused3;
    logic go;
    logic unused1;
    logic converter_on;
  } conv_ctrl_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_SAMPLE = 3'b010,
    ENG_CONVERT = 3'b100
  } eng_state_t;

endpackage

// ---- sar_sync2.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for levels arriving from outside the clock domain.
module sar_sync2 import sar_adc_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// ---- sar_engine.sv ----
`timescale 1ns/1ps
// Sample phase followed by a bitwise successive-approximation search.
module sar_engine import sar_adc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic abort,
  input wire logic step_en,
  input wire logic cmp_high,
  output logic busy,
  output logic sampling,
  output logic done,
  output logic [RESULT_BITS-1:0] trial,
  output logic [RESULT_BITS-1:0] result
);
  eng_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [RESULT_BITS-1:0] next_trial, next_result;
  logic next_done;

  // Next-state logic for the sample and search phases.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_trial = trial;
    next_result = result;
    next_done = 1'b0;
    case (state)
      ENG_IDLE:
      begin
        if (start)
        begin
          next_state = ENG_SAMPLE;
          next_cnt = 4'h0;
          next_trial = '0;
        end
      end
      ENG_SAMPLE:
      begin
        if (abort)
          next_state = ENG_IDLE;
        else if (step_en && cnt == 4'(ACQ_TAD - 1))
        begin
          next_state = ENG_CONVERT;
          next_cnt = 4'(RESULT_BITS - 1);
          next_trial = TRIAL_MSB;
        end
        else if (step_en)
          next_cnt = cnt + 4'h1;
      end
      ENG_CONVERT:
      begin
        if (abort)
          next_state = ENG_IDLE;
        else if (step_en)
        begin
          if (!cmp_high)
            next_trial[cnt] = 1'b0;
          if (cnt == 4'h0)
          begin
            next_result = next_trial;
            next_done = 1'b1;
            next_state = ENG_IDLE;
          end
          else
          begin
            next_cnt = cnt - 4'h1;
            next_trial[cnt - 4'h1] = 1'b1;
          end
        end
      end
      default: next_state = ENG_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= ENG_IDLE;
      cnt <= 4'h0;
      trial <= '0;
      result <= '0;
      done <= 1'b0;
      busy <= 1'b0;
      sampling <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      trial <= next_trial;
      result <= next_result;
      done <= next_done;
      busy <= next_state != ENG_IDLE;
      sampling <= next_state == ENG_SAMPLE;
    end
  end

  sequence s_enter_convert;
    state == ENG_SAMPLE ##1 state == ENG_CONVERT;
  endsequence

  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (srst)
    s_enter_convert |-> trial == TRIAL_MSB)
    else $error("Search did not start at the top bit.");

  AST_SAMPLE_FIRST: assert property (@(posedge clk) disable iff (srst)
    (state == ENG_IDLE && start) |=> sampling ##1 (sampling || !busy))
    else $error("Start did not open the sample phase.");
endmodule

// ---- analog_frontend.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Analog side: input pins, hold capacitor and comparator.
// ----------------------------------------
module analog_frontend
(
  input wire logic sample_close,
  input wire logic [9:0] dac_code,
  input wire logic [3:0] mux_channel,
  input wire logic [159:0] pin_levels,
  output logic cmp_pin
);
  logic [9:0] held = 10'h000;

  // Hold the selected input when the sample switch opens.
  // selected input held
  always @(negedge sample_close)
    held = pin_levels[mux_channel*10 +: 10];

  // Comparator is high while the held level reaches the trial code.
  // trial compare
  assign cmp_pin = (held >= dac_code);
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench import sar_adc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, cmp_pin, sample_close, vpos, vneg, power, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [9:0] dac_code, lvl;
  logic [3:0] mux_channel, ch;
  logic [15:0] pin_en;
  logic [159:0] pin_levels = 160'h0;
  logic [34:0] exp_q[$];
  logic [34:0] note;
  logic sleep = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;

  always #2 clk = ~clk;

  sar_adc_control #(.CHANNELS(16), .TAD_CNT(4)) sar_adc_control_inst (.clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmp_pin(cmp_pin), .sleep_mode(sleep), .sample_close(sample_close),
    .dac_code(dac_code), .mux_channel(mux_channel), .vref_pos_from_pin(vpos), .vref_neg_from_pin(vneg),
    .analog_pin_enable(pin_en), .converter_power(power), .irq(irq));

  analog_frontend analog_frontend_inst (.sample_close(sample_close), .dac_code(dac_code),
    .mux_channel(mux_channel), .pin_levels(pin_levels), .cmp_pin(cmp_pin));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write one word and check the response code.
  task wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] resp);
    int n;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end
    while (!(bvalid === 1'b1) && n < 100);
    if (n >= 100)
    begin
      num_errors++;
      end_sim();
    end
    chk({32'h0, bresp}, {32'h0, resp});
  endtask

  // Read one word; the expectation goes to the queue, chk_en 0 for polling.
  task rd_reg(input logic [5:0] idx, input logic chk_en, input logic [33:0] exp);
    int n;
    exp_q.push_back({chk_en, exp});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end
    while (!(rvalid === 1'b1) && n < 100);
    rd = rdata;
    if (n >= 100)
    begin
      num_errors++;
      end_sim();
    end
  endtask

  // Pop the oldest queued note for each read answer; compare the answer only if its chk_en is set.
  always @(posedge clk)
    if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[34])
        chk({rresp, rdata}, note[33:0]);
    end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int n;
    void'($urandom(32'h9e1b));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(IDX_CONV_CTRL, 1'b1, {RESP_OKAY, 32'h0});
    rd_reg(IDX_PIN_CONFIG, 1'b1, {RESP_OKAY, 32'h0});
    rd_reg(6'h3F, 1'b1, {RESP_SLVERR, 32'h0});
    wr(6'h3F, 32'h1, RESP_SLVERR);
    $display("test reset and map done");
    wr(IDX_ANALOG_CONFIG, 32'h0001A5C3, RESP_OKAY);
    wr(IDX_INT_MASK, 32'h1, RESP_OKAY);
    chk({vneg, vpos, pin_en}, {16'h0, 2'b01, 16'hA5C3});
    for (int i = 0; i < 4; i++)
    begin
      ch = 4'($urandom % 16);
      lvl = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
      pin_levels[ch*10 +: 10] <= lvl;
      wr(IDX_CONV_CTRL, {24'h0, ch, 4'h5}, RESP_OKAY);
      chk({30'h0, mux_channel}, {30'h0, ch});
      n = 0;
      do
      begin
        rd_reg(IDX_CONV_CTRL, 1'b0, 34'h0);
        n++;
      end
      while (rd[2] !== 1'b0 && n < 60);
      if (n >= 60)
      begin
        num_errors++;
        end_sim();
      end
      rd_reg(IDX_CONV_CTRL, 1'b1, {RESP_OKAY, 24'h0, ch, 4'h1});
      rd_reg(IDX_RESULT_HIGH, 1'b1, {RESP_OKAY, 30'h0, lvl[9:8]});
      rd_reg(IDX_RESULT_LOW, 1'b1, {RESP_OKAY, 24'h0, lvl[7:0]});
      chk({33'h0, irq}, 34'h1);
      wr(IDX_INT_STATUS, 32'h1, RESP_OKAY);
      @(posedge clk);
      chk({33'h0, irq}, 34'h0);
    end
    $display("test conversions done");
    sleep <= 1'b1;
    wr(IDX_CONV_CTRL, 32'h00000025, RESP_OKAY);
    repeat (150) @(posedge clk);
    rd_reg(IDX_CONV_CTRL, 1'b1, {RESP_OKAY, 32'h25});
    sleep <= 1'b0;
    $display("test sleep stall done");
    wr(IDX_CONV_CTRL, 32'h00000034, RESP_OKAY);
    repeat (3) @(posedge clk);
    rd_reg(IDX_CONV_CTRL, 1'b1, {RESP_OKAY, 32'h30});
    chk({32'h0, power, sample_close}, 34'h0);
    $display("test converter off done");
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
